// ---- inc/rtsi_cfg.svh ----
// Purpose: Constants of the race timer serial input block
// Assumes: 50 MHz system clock
// Notes: Included by the design file and the bench
//
// Behaviour
// - Link runs 9600 baud, one start, eight data, two stop, no parity.
// - In race code, received race data goes to the scoreboard output.
// - All-segments test key drives an all-on scoreboard pattern.
// - Digit test key drives a numeric scoreboard pattern.
// - After any received data, test keys ignored until restarted in race code.
// - Normal-view key returns scoreboard to received data, dropping test pattern.
// - A loopback key pressed while the transmitter is idle sends its canned data out of the transmit pin.
// - Each loopback key pair addresses one lane line: top/bottom, left/right.
// - Received data shown on LCD bottom line, preceded by a greater-than symbol.
`ifndef RTSI_CFG_SVH
`define RTSI_CFG_SVH

`define RTSI_CLK_HZ 50000000
`define RTSI_BAUD 9600
`define RTSI_BIT_CYC ((`RTSI_CLK_HZ) / (`RTSI_BAUD))
`define RTSI_DATA_BITS 8
`define RTSI_STOP_BITS 2
`define RTSI_FRAME_BITS 11
`define RTSI_RACE_CODE 10'h1F6
`define RTSI_CR 8'h0D
`define RTSI_PROMPT 8'h3E
`define RTSI_DEST_BASE 8'h41
`define RTSI_DIGIT_BASE 8'h30
`define RTSI_EIGHT 8'h38
`define RTSI_MSG_LEN 3'h5
`define RTSI_FIFO_DEPTH 4

`endif

// ---- inc/rtsi_pkg.sv ----
// Purpose: Types of the race timer serial input block
// Assumes: Nothing beyond the constants header
// Notes: Carriers for the scoreboard and LCD streams
package rtsi_pkg;

	typedef enum logic [1:0] {RTSI_PAT_LIVE, RTSI_PAT_ALL_ON, RTSI_PAT_NUMBER} rtsi_pat_t;

	typedef struct packed {
		rtsi_pat_t pattern;
		logic valid;
		logic [7:0] data;
	} rtsi_sb_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rtsi_lcd_t;

endpackage

// ---- verilog/rtsi_top.sv ----
// Purpose: Serial receive path from a race timer, test keys and loopback transmit
// Assumes: Keys are one-cycle pulses from a key scanner on clk_sys
// Notes: FIFO and top share this file
`timescale 1ns/1ps
`include "rtsi_cfg.svh"

module rtsi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `RTSI_FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic push, pop;

	always_comb
	begin
		in_ready = (cnt_ff != (AW+1)'(DEPTH));
		out_valid = (cnt_ff != '0);
		out_data = mem_ff[rd_ff];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		nxt_wr = push ? ((wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1) : wr_ff;
		nxt_rd = pop ? ((rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1) : rd_ff;
		nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end

	// Storage needs no reset; reads are gated by the count
	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem_ff[wr_ff] <= in_data;
	end
endmodule

module rtsi_top #(
	parameter int BIT_CYC = `RTSI_BIT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic serial_jack_rx,
	output logic serial_jack_tx,
	input wire logic code_load,
	input wire logic [9:0] code_value,
	input wire logic key_all_on,
	input wire logic key_number,
	input wire logic key_normal,
	input wire logic [7:0] key_loop,
	output rtsi_pkg::rtsi_sb_t board_ff,
	output rtsi_pkg::rtsi_lcd_t lcd_ff,
	output logic lockout_ff
);
	import rtsi_pkg::*;

	// ******************************
	// Reset and pin synchronisers
	// ******************************
	logic rst_meta_ff, rst_sync_ff, rx_meta_ff, rx_ff;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
		begin
			rx_meta_ff <= 1'b1;
			rx_ff <= 1'b1;
		end
		else
		begin
			rx_meta_ff <= serial_jack_rx;
			rx_ff <= rx_meta_ff;
		end
	end

	// ******************************
	// Receiver
	// ******************************
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rtsi_rx_t;
	rtsi_rx_t rx_st_ff, nxt_rx_st;
	logic [15:0] rx_cnt_ff, nxt_rx_cnt;
	logic [2:0] rx_bit_ff, nxt_rx_bit;
	logic [7:0] rx_sh_ff, nxt_rx_sh;
	logic rx_hold_ff, nxt_rx_hold, rx_good;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [7:0] fifo_out_data;

	always_comb
	begin
		nxt_rx_st = rx_st_ff;
		nxt_rx_cnt = (rx_cnt_ff == '0) ? 16'(BIT_CYC - 1) : rx_cnt_ff - 1'b1;
		nxt_rx_bit = rx_bit_ff;
		nxt_rx_sh = rx_sh_ff;
		nxt_rx_hold = rx_hold_ff && !fifo_in_ready;
		rx_good = 1'b0;
		case (rx_st_ff)
			RX_IDLE:
			begin
				nxt_rx_cnt = 16'(BIT_CYC / 2);
				if (!rx_ff)
					nxt_rx_st = RX_START;
			end
			RX_START:
				if (rx_cnt_ff == '0)
				begin
					nxt_rx_st = rx_ff ? RX_IDLE : RX_DATA;
					nxt_rx_bit = '0;
				end
			RX_DATA:
				if (rx_cnt_ff == '0)
				begin
					nxt_rx_sh = {rx_ff, rx_sh_ff[7:1]};
					nxt_rx_bit = rx_bit_ff + 1'b1;
					if (rx_bit_ff == 3'(`RTSI_DATA_BITS - 1))
					begin
						nxt_rx_st = RX_STOP;
						nxt_rx_bit = '0;
					end
				end
			RX_STOP:
				if (rx_cnt_ff == '0)
				begin
					nxt_rx_bit = rx_bit_ff + 1'b1;
					if (!rx_ff)
						nxt_rx_st = RX_IDLE;
					else if (rx_bit_ff == 3'(`RTSI_STOP_BITS - 1))
					begin
						nxt_rx_st = RX_IDLE;
						rx_good = 1'b1;
						nxt_rx_hold = 1'b1;
					end
				end
			default:
				nxt_rx_st = RX_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
		begin
			rx_st_ff <= RX_IDLE;
			rx_cnt_ff <= '0;
			rx_bit_ff <= '0;
			rx_sh_ff <= '0;
			rx_hold_ff <= 1'b0;
		end
		else
		begin
			rx_st_ff <= nxt_rx_st;
			rx_cnt_ff <= nxt_rx_cnt;
			rx_bit_ff <= nxt_rx_bit;
			rx_sh_ff <= nxt_rx_sh;
			rx_hold_ff <= nxt_rx_hold;
		end
	end

	// Line cannot be stalled: a character still held when the next lands is lost
	rtsi_fifo #(.WIDTH(8), .DEPTH(`RTSI_FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_sync_ff),
		.in_valid(rx_hold_ff),
		.in_ready(fifo_in_ready),
		.in_data(rx_sh_ff),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// ******************************
	// Mode, lockout, scoreboard and LCD
	// ******************************
	logic race_mode_ff, nxt_race_mode, nxt_lockout, line_start_ff, nxt_line_start;
	rtsi_sb_t nxt_board;
	rtsi_lcd_t nxt_lcd;

	always_comb
	begin
		nxt_race_mode = code_load ? (code_value == `RTSI_RACE_CODE) : race_mode_ff;
		// Fresh data wins over a restart in the same cycle
		nxt_lockout = rx_good || (lockout_ff && !(code_load && code_value == `RTSI_RACE_CODE));
		nxt_board = board_ff;
		nxt_board.valid = 1'b0;
		nxt_lcd = '0;
		nxt_line_start = line_start_ff;
		// Prompt takes a cycle of its own, stalling the FIFO
		fifo_out_ready = fifo_out_valid && !line_start_ff;
		if (key_normal)
			nxt_board.pattern = RTSI_PAT_LIVE;
		else if (key_all_on && !lockout_ff)
			nxt_board.pattern = RTSI_PAT_ALL_ON;
		else if (key_number && !lockout_ff)
			nxt_board.pattern = RTSI_PAT_NUMBER;
		if (fifo_out_valid)
		begin
			nxt_lcd.valid = 1'b1;
			if (line_start_ff)
			begin
				nxt_lcd.data = `RTSI_PROMPT;
				nxt_line_start = 1'b0;
			end
			else
			begin
				nxt_lcd.data = fifo_out_data;
				nxt_line_start = (fifo_out_data == `RTSI_CR);
				nxt_board.valid = race_mode_ff;
				nxt_board.data = fifo_out_data;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
		begin
			race_mode_ff <= 1'b0;
			lockout_ff <= 1'b0;
			line_start_ff <= 1'b1;
			board_ff <= '{pattern: RTSI_PAT_LIVE, valid: 1'b0, data: 8'h00};
			lcd_ff <= '0;
		end
		else
		begin
			race_mode_ff <= nxt_race_mode;
			lockout_ff <= nxt_lockout;
			line_start_ff <= nxt_line_start;
			board_ff <= nxt_board;
			lcd_ff <= nxt_lcd;
		end
	end

	// ******************************
	// Loopback transmitter
	// ******************************
	logic tx_busy_ff, nxt_tx_busy, nxt_tx;
	logic [2:0] tx_key_ff, nxt_tx_key, tx_pos_ff, nxt_tx_pos, key_idx;
	logic [3:0] tx_bit_ff, nxt_tx_bit;
	logic [10:0] tx_sh_ff, nxt_tx_sh;
	logic [15:0] tx_cnt_ff, nxt_tx_cnt;

	// Pair selects the lane line, odd key of a pair sends eights
	function automatic logic [7:0] canned(input logic [2:0] key, input logic [2:0] pos);
		logic [7:0] ch;
		ch = key[0] ? `RTSI_EIGHT : `RTSI_DIGIT_BASE + 8'(pos);
		if (pos == 3'h0)
			ch = `RTSI_DEST_BASE + 8'(key[2:1]);
		else if (pos == `RTSI_MSG_LEN - 3'h1)
			ch = `RTSI_CR;
		return ch;
	endfunction

	always_comb
	begin
		key_idx = '0;
		for (int i = 7; i >= 0; i--)
			if (key_loop[i])
				key_idx = 3'(i);
		nxt_tx_busy = tx_busy_ff;
		nxt_tx_key = tx_key_ff;
		nxt_tx_pos = tx_pos_ff;
		nxt_tx_bit = tx_bit_ff;
		nxt_tx_sh = tx_sh_ff;
		nxt_tx_cnt = (tx_cnt_ff == '0) ? 16'(BIT_CYC - 1) : tx_cnt_ff - 1'b1;
		if (!tx_busy_ff)
		begin
			nxt_tx_cnt = 16'(BIT_CYC - 1);
			if (key_loop != '0)
			begin
				nxt_tx_busy = 1'b1;
				nxt_tx_key = key_idx;
				nxt_tx_pos = '0;
				nxt_tx_bit = '0;
				nxt_tx_sh = {2'b11, canned(key_idx, 3'h0), 1'b0};
			end
		end
		else if (tx_cnt_ff == '0)
		begin
			nxt_tx_sh = {1'b1, tx_sh_ff[10:1]};
			nxt_tx_bit = tx_bit_ff + 1'b1;
			if (tx_bit_ff == 4'(`RTSI_FRAME_BITS - 1))
			begin
				nxt_tx_bit = '0;
				nxt_tx_pos = tx_pos_ff + 1'b1;
				nxt_tx_sh = {2'b11, canned(tx_key_ff, tx_pos_ff + 1'b1), 1'b0};
				if (tx_pos_ff == `RTSI_MSG_LEN - 3'h1)
					nxt_tx_busy = 1'b0;
			end
		end
		nxt_tx = nxt_tx_busy ? nxt_tx_sh[0] : 1'b1;
	end

	always_ff @(posedge clk_sys or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
		begin
			tx_busy_ff <= 1'b0;
			tx_key_ff <= '0;
			tx_pos_ff <= '0;
			tx_bit_ff <= '0;
			tx_sh_ff <= '1;
			tx_cnt_ff <= '0;
			serial_jack_tx <= 1'b1;
		end
		else
		begin
			tx_busy_ff <= nxt_tx_busy;
			tx_key_ff <= nxt_tx_key;
			tx_pos_ff <= nxt_tx_pos;
			tx_bit_ff <= nxt_tx_bit;
			tx_sh_ff <= nxt_tx_sh;
			tx_cnt_ff <= nxt_tx_cnt;
			serial_jack_tx <= nxt_tx;
		end
	end
endmodule

// ---- bench/rtsi_timer_model.sv ----
// Purpose: Race timer stand-in on the serial line
// Assumes: Line rests at mark level between frames
// Notes: Bad stop bit only when a test asks
`timescale 1ns/1ps
module rtsi_timer_model #(
	parameter int BIT_CYC = 16
) (
	input wire logic clk_sys,
	output logic line
);
	initial line = 1'b1;
	task automatic send(input logic [7:0] b, input logic stop_ok);
		logic [10:0] f;
		f = {1'b1, stop_ok, b, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			@(posedge clk_sys);
			line <= f[i];
			repeat (BIT_CYC - 1) @(posedge clk_sys);
		end
	endtask
endmodule

// ---- bench/rtsi_asserts.sv ----
// Purpose: Port checks of the race timer serial input
// Assumes: One clock domain
// Notes: Quiet count marks an idle transmitter
`timescale 1ns/1ps
`include "rtsi_cfg.svh"
module rtsi_asserts #(
	parameter int BIT_CYC = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic serial_jack_tx,
	input wire logic code_load,
	input wire logic [9:0] code_value,
	input wire logic key_all_on,
	input wire logic key_number,
	input wire logic key_normal,
	input wire logic [7:0] key_loop,
	input wire rtsi_pkg::rtsi_sb_t board_ff,
	input wire rtsi_pkg::rtsi_lcd_t lcd_ff,
	input wire logic lockout_ff
);
	import rtsi_pkg::*;
	logic [15:0] quiet_ff;
	logic [15:0] nxt_quiet;
	always_comb
	begin
		nxt_quiet = serial_jack_tx ? quiet_ff + 16'(!quiet_ff[15]) : 16'h0;
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			quiet_ff <= 16'h0;
		else
			quiet_ff <= nxt_quiet;
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	chk_normal_view: assert property (key_normal
		|=> board_ff.pattern == RTSI_PAT_LIVE) else $error("normal key failed");
	chk_all_on: assert property (key_all_on && !key_normal && !lockout_ff
		|=> board_ff.pattern == RTSI_PAT_ALL_ON) else $error("all on failed");
	chk_number_pat: assert property (key_number && !(key_all_on || key_normal)
		&& !lockout_ff |=> board_ff.pattern == RTSI_PAT_NUMBER) else $error("number failed");
	chk_lock_keys: assert property (lockout_ff && !key_normal
		|=> $stable(board_ff.pattern)) else $error("locked key acted");
	chk_lock_hold: assert property (lockout_ff && !(code_load
		&& code_value == `RTSI_RACE_CODE) |=> lockout_ff) else $error("lockout lost");
	// Limitation: a received greater-than char at a line start also trips this
	chk_prompt_next: assert property (lcd_ff.valid && lcd_ff.data == `RTSI_PROMPT
		|=> lcd_ff.valid && lcd_ff.data != `RTSI_PROMPT) else $error("prompt alone");
	chk_tx_start: assert property (|key_loop && quiet_ff > 16'(12 * BIT_CYC)
		|=> !serial_jack_tx) else $error("no start bit");
	chk_tx_bit_len: assert property ($fell(serial_jack_tx)
		|-> !serial_jack_tx [*8]) else $error("short low bit");
	cov_all_on: cover property (key_all_on ##1 board_ff.pattern == RTSI_PAT_ALL_ON);
	cov_lock: cover property ($rose(lockout_ff));
	cov_loop: cover property (|key_loop ##1 !serial_jack_tx);
	cov_board_char: cover property (lcd_ff.valid && board_ff.valid);
endmodule
bind rtsi_top rtsi_asserts #(.BIT_CYC(BIT_CYC)) rtsi_asserts_inst (.clk_sys(clk_sys),
	.rst_n(rst_n), .serial_jack_tx(serial_jack_tx), .code_load(code_load),
	.code_value(code_value), .key_all_on(key_all_on), .key_number(key_number),
	.key_normal(key_normal), .key_loop(key_loop), .board_ff(board_ff), .lcd_ff(lcd_ff),
	.lockout_ff(lockout_ff));

// ---- bench/rtsi_top_tb.sv ----
// Purpose: Self-checking bench of the race timer serial input
// Assumes: Bit time cut to 16 cycles
// Notes: Strap ANDs tx with the timer line
`timescale 1ns/1ps
`include "rtsi_cfg.svh"
module rtsi_top_tb;
	import rtsi_pkg::*;
	localparam int BC = 16;
	logic clk_sys = 1'b0, rst_n = 1'b0, code_load = 1'b0, tx, line, lock;
	logic key_all_on = 1'b0, key_number = 1'b0, key_normal = 1'b0;
	logic [9:0] code_value = 10'h0;
	logic [7:0] key_loop = 8'h0;
	logic [7:0] lcd_q[$], board_q[$];
	rtsi_sb_t board;
	rtsi_lcd_t lcd;
	int error_cnt = 0, num_checks = 0;
	wire rx = line & tx;
	rtsi_top #(.BIT_CYC(BC)) rtsi_top_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.serial_jack_rx(rx), .serial_jack_tx(tx), .code_load(code_load),
		.code_value(code_value), .key_all_on(key_all_on), .key_number(key_number),
		.key_normal(key_normal), .key_loop(key_loop), .board_ff(board), .lcd_ff(lcd),
		.lockout_ff(lock));
	rtsi_timer_model #(.BIT_CYC(BC)) rtsi_timer_model_inst (.clk_sys(clk_sys), .line(line));
	initial
	begin
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		if (lcd.valid === 1'b1)
			lcd_q.push_back(lcd.data);
		if (board.valid === 1'b1)
			board_q.push_back(board.data);
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic press(input logic [2:0] k, input rtsi_pat_t pat);
		@(posedge clk_sys);
		{key_normal, key_number, key_all_on} <= k;
		@(posedge clk_sys);
		{key_normal, key_number, key_all_on} <= 3'h0;
		@(negedge clk_sys);
		chk("pattern", {6'h0, pat}, {6'h0, board.pattern});
	endtask
	task automatic load(input logic [9:0] c);
		@(posedge clk_sys);
		code_load <= 1'b1;
		code_value <= c;
		@(posedge clk_sys);
		code_load <= 1'b0;
	endtask
	task automatic wait_lcd(input int n);
		for (int i = 0; i < 4000 && lcd_q.size() < n; i++)
			@(posedge clk_sys);
		repeat (16 * BC) @(posedge clk_sys);
		// Outputs are looked at away from the edge that updates them
		@(negedge clk_sys);
	endtask
	task automatic t_keys();
		press(3'h1, RTSI_PAT_ALL_ON);
		press(3'h2, RTSI_PAT_NUMBER);
		press(3'h3, RTSI_PAT_ALL_ON);
		press(3'h6, RTSI_PAT_LIVE);
	endtask
	task automatic t_rx();
		load(`RTSI_RACE_CODE);
		rtsi_timer_model_inst.send(8'h5A, 1'b0);
		repeat (2 * BC) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("lockout", 8'h0, {7'h0, lock});
		rtsi_timer_model_inst.send(8'h5A, 1'b1);
		rtsi_timer_model_inst.send(`RTSI_CR, 1'b1);
		wait_lcd(3);
		chk("lcd count", 8'h3, 8'(lcd_q.size()));
		chk("prompt", `RTSI_PROMPT, lcd_q[0]);
		chk("lcd char", 8'h5A, lcd_q[1]);
		chk("board char", 8'h5A, board_q[0]);
		chk("lockout", 8'h1, {7'h0, lock});
		press(3'h1, RTSI_PAT_LIVE);
		press(3'h2, RTSI_PAT_LIVE);
		load(`RTSI_RACE_CODE);
		press(3'h2, RTSI_PAT_NUMBER);
	endtask
	task automatic t_loop();
		logic [7:0] e;
		load(10'h001);
		board_q.delete();
		for (int k = 0; k < 8; k++)
		begin
			lcd_q.delete();
			@(posedge clk_sys);
			key_loop <= 8'h1 << k;
			@(posedge clk_sys);
			key_loop <= 8'h80 >> k;
			@(posedge clk_sys);
			key_loop <= 8'h0;
			wait_lcd(6);
			chk("lcd count", 8'h6, 8'(lcd_q.size()));
			chk("dest", `RTSI_DEST_BASE + 8'(k / 2), lcd_q[1]);
			e = k[0] ? `RTSI_EIGHT : `RTSI_DIGIT_BASE + 8'h1;
			chk("digit", e, lcd_q[2]);
			e = k[0] ? `RTSI_EIGHT : `RTSI_DIGIT_BASE + 8'h3;
			chk("last digit", e, lcd_q[4]);
			chk("end", `RTSI_CR, lcd_q[5]);
		end
		chk("board count", 8'h0, 8'(board_q.size()));
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_keys();
		t_rx();
		t_loop();
		print_verdict();
	end
	// Run needs about 10000 cycles; five times that is a hang
	initial
	begin
		#1ms;
		error_cnt++;
		print_verdict();
	end
endmodule
